// file: cwalm_defs.vh
`ifndef CWALM_DEFS_VH
`define CWALM_DEFS_VH

// Register byte offsets
`define CWALM_OFS_LIVE 6'h00
`define CWALM_OFS_DATE_MATCH 6'h04
`define CWALM_OFS_DATE_LOAD 6'h08
`define CWALM_OFS_YEAR_LIVE 6'h0C
`define CWALM_OFS_YEAR_MATCH 6'h10
`define CWALM_OFS_YEAR_LOAD 6'h14
`define CWALM_OFS_IRQ_STAT 6'h18
`define CWALM_OFS_IRQ_MASK 6'h1C
`define CWALM_OFS_TICK_CTRL 6'h20

// Date word field positions
`define CWALM_SEC_HI 5
`define CWALM_SEC_LO 0
`define CWALM_MIN_HI 11
`define CWALM_MIN_LO 6
`define CWALM_HOUR_HI 16
`define CWALM_HOUR_LO 12
`define CWALM_WDAY_HI 19
`define CWALM_WDAY_LO 17
`define CWALM_MDAY_HI 24
`define CWALM_MDAY_LO 20
`define CWALM_MON_HI 28
`define CWALM_MON_LO 25
`define CWALM_DATE_BITS 29
`define CWALM_YEAR_BITS 14

// Field limits
`define CWALM_SEC_MAX 6'h3B
`define CWALM_HOUR_MAX 5'h17
`define CWALM_MON_MAX 4'hC

// Reset values
`define CWALM_DATE_LIVE_RST 29'h02120000
`define CWALM_YEAR_RST 14'h2000

// Interrupt status bits
`define CWALM_IRQ_ALARM 0
`define CWALM_IRQ_TIMER 1

`endif

// file: cwalm_field_cmp.v
`timescale 1ns/100ps
`include "cwalm_defs.vh"

// One alarm field compare with optional zero don't-care and max limit
module cwalm_field_cmp #(
    parameter W = 6,
    parameter [W-1:0] MAXV = {W{1'b1}},
    parameter ZERO_ANY = 0
) (
    // Field values
    input wire [W-1:0] alarmVal,
    input wire [W-1:0] liveVal,
    // Result
    output wire hit
);
    // Out-of-range codes never match; zero may mean don't care
    assign hit = (alarmVal > MAXV) ? 1'b0 :
        ((ZERO_ANY != 0) && (alarmVal == {W{1'b0}})) ? 1'b1 :
        (alarmVal == liveVal);
endmodule

// file: cwalm_alarm_regs.v
`timescale 1ns/100ps
`include "cwalm_defs.vh"

// How it works
// - Seconds alarm 0-59 compares; 60-63 never match
// - Minutes alarm 0-59 compares; 60-63 never match
// - Hours alarm 0-23 compares; 24-31 never match
// - Weekday alarm zero is don't care
// - Day-of-month alarm zero is don't care
// - Month alarm zero don't care; 13-15 never
// - Live year read-only BCD, resets 2000h
// - Year alarm BCD, resets 2000h, compared
// - Year load BCD field resets to zero
// - Compare after each increment, raise alarm
// - Combined interrupt ORs masked alarm and timer
module cwalm_alarm_regs (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Register port
    input wire [5:0] regAddr,
    input wire [31:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [31:0] regRdata_r,
    // Calendar engine side
    input wire calTick,
    input wire [28:0] dateNext,
    input wire [13:0] yearNext,
    input wire timerIrq,
    output reg [28:0] dateLiveWord_r,
    output reg [13:0] yearLive_r,
    // Interrupts
    output reg alarmIrq_r,
    output reg combinedIrq_r
);
    reg [28:0] dateMatch_r;
    reg [28:0] dateLoad_r;
    reg [13:0] yearAlarm_r;
    reg [13:0] yearLoad_r;
    reg [1:0] irqStat_r;
    reg [1:0] irqMask_r;
    reg tickEn_r;
    reg cmpPend_r;
    reg [31:0] rdata_nxt;
    reg [1:0] irqStat_nxt;
    wire hitSec;
    wire hitMin;
    wire hitHour;
    wire hitWday;
    wire hitMday;
    wire hitMon;
    wire dateHit;
    wire yearHit;
    wire wrDateLoad;
    wire wrYearLoad;

    assign wrDateLoad = regWr && (regAddr == `CWALM_OFS_DATE_LOAD);
    assign wrYearLoad = regWr && (regAddr == `CWALM_OFS_YEAR_LOAD);

    // Field compares
    cwalm_field_cmp #(.W(6), .MAXV(`CWALM_SEC_MAX), .ZERO_ANY(0)) uSec (
        .alarmVal(dateMatch_r[`CWALM_SEC_HI:`CWALM_SEC_LO]),
        .liveVal(dateLiveWord_r[`CWALM_SEC_HI:`CWALM_SEC_LO]),
        .hit(hitSec)
    );
    cwalm_field_cmp #(.W(6), .MAXV(`CWALM_SEC_MAX), .ZERO_ANY(0)) uMin (
        .alarmVal(dateMatch_r[`CWALM_MIN_HI:`CWALM_MIN_LO]),
        .liveVal(dateLiveWord_r[`CWALM_MIN_HI:`CWALM_MIN_LO]),
        .hit(hitMin)
    );
    cwalm_field_cmp #(.W(5), .MAXV(`CWALM_HOUR_MAX), .ZERO_ANY(0)) uHour (
        .alarmVal(dateMatch_r[`CWALM_HOUR_HI:`CWALM_HOUR_LO]),
        .liveVal(dateLiveWord_r[`CWALM_HOUR_HI:`CWALM_HOUR_LO]),
        .hit(hitHour)
    );
    cwalm_field_cmp #(.W(3), .MAXV(3'h7), .ZERO_ANY(1)) uWday (
        .alarmVal(dateMatch_r[`CWALM_WDAY_HI:`CWALM_WDAY_LO]),
        .liveVal(dateLiveWord_r[`CWALM_WDAY_HI:`CWALM_WDAY_LO]),
        .hit(hitWday)
    );
    cwalm_field_cmp #(.W(5), .MAXV(5'h1F), .ZERO_ANY(1)) uMday (
        .alarmVal(dateMatch_r[`CWALM_MDAY_HI:`CWALM_MDAY_LO]),
        .liveVal(dateLiveWord_r[`CWALM_MDAY_HI:`CWALM_MDAY_LO]),
        .hit(hitMday)
    );
    cwalm_field_cmp #(.W(4), .MAXV(`CWALM_MON_MAX), .ZERO_ANY(1)) uMon (
        .alarmVal(dateMatch_r[`CWALM_MON_HI:`CWALM_MON_LO]),
        .liveVal(dateLiveWord_r[`CWALM_MON_HI:`CWALM_MON_LO]),
        .hit(hitMon)
    );

    // Whole date and year agreement
    assign dateHit = hitSec && hitMin && hitHour && hitWday && hitMday
        && hitMon;
    assign yearHit = (yearAlarm_r == yearLive_r);

    // Software-written registers
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            dateMatch_r <= 29'h0;
            dateLoad_r <= 29'h0;
            yearAlarm_r <= `CWALM_YEAR_RST;
            yearLoad_r <= 14'h0;
            irqMask_r <= 2'h0;
            tickEn_r <= 1'b0;
        end
        else if (regWr)
        begin
            case (regAddr)
                `CWALM_OFS_DATE_MATCH:
                    dateMatch_r <= regWdata[28:0];
                `CWALM_OFS_DATE_LOAD:
                    dateLoad_r <= regWdata[28:0];
                `CWALM_OFS_YEAR_MATCH:
                    yearAlarm_r <= regWdata[13:0];
                `CWALM_OFS_YEAR_LOAD:
                    yearLoad_r <= regWdata[13:0];
                `CWALM_OFS_IRQ_MASK:
                    irqMask_r <= regWdata[1:0];
                `CWALM_OFS_TICK_CTRL:
                    tickEn_r <= regWdata[0];
                default:
                    tickEn_r <= tickEn_r;
            endcase
        end
    end

    // Live calendar: load on write, else follow engine on tick while tick enable is set
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            dateLiveWord_r <= `CWALM_DATE_LIVE_RST;
            yearLive_r <= `CWALM_YEAR_RST;
            cmpPend_r <= 1'b0;
        end
        else
        begin
            if (wrDateLoad)
                dateLiveWord_r <= regWdata[28:0];
            else if (calTick && tickEn_r)
                dateLiveWord_r <= dateNext;
            if (wrYearLoad)
                yearLive_r <= regWdata[13:0];
            else if (calTick && tickEn_r)
                yearLive_r <= yearNext;
            // Compare one cycle after each increment
            cmpPend_r <= calTick && tickEn_r;
        end
    end

    // Sticky status: set beats write-one clear
    always @*
    begin
        irqStat_nxt = irqStat_r;
        if (regWr && (regAddr == `CWALM_OFS_IRQ_STAT))
            irqStat_nxt = irqStat_r & ~regWdata[1:0];
        if (cmpPend_r && dateHit && yearHit)
            irqStat_nxt[`CWALM_IRQ_ALARM] = 1'b1;
        if (timerIrq)
            irqStat_nxt[`CWALM_IRQ_TIMER] = 1'b1;
    end

    // Status and interrupt outputs
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            irqStat_r <= 2'h0;
            alarmIrq_r <= 1'b0;
            combinedIrq_r <= 1'b0;
        end
        else
        begin
            irqStat_r <= irqStat_nxt;
            alarmIrq_r <= irqStat_nxt[`CWALM_IRQ_ALARM]
                & irqMask_r[`CWALM_IRQ_ALARM];
            combinedIrq_r <= |(irqStat_nxt & irqMask_r);
        end
    end

    // Read mux, unmapped reads give zero
    always @*
    begin
        rdata_nxt = 32'h0;
        case (regAddr)
            `CWALM_OFS_LIVE:
                rdata_nxt = {3'h0, dateLiveWord_r};
            `CWALM_OFS_DATE_MATCH:
                rdata_nxt = {3'h0, dateMatch_r};
            `CWALM_OFS_DATE_LOAD:
                rdata_nxt = {3'h0, dateLoad_r};
            `CWALM_OFS_YEAR_LIVE:
                rdata_nxt = {18'h0, yearLive_r};
            `CWALM_OFS_YEAR_MATCH:
                rdata_nxt = {18'h0, yearAlarm_r};
            `CWALM_OFS_YEAR_LOAD:
                rdata_nxt = {18'h0, yearLoad_r};
            `CWALM_OFS_IRQ_STAT:
                rdata_nxt = {30'h0, irqStat_r};
            `CWALM_OFS_IRQ_MASK:
                rdata_nxt = {30'h0, irqMask_r};
            `CWALM_OFS_TICK_CTRL:
                rdata_nxt = {31'h0, tickEn_r};
            default:
                rdata_nxt = 32'h0;
        endcase
    end

    // Read data valid only the cycle after the strobe
    always @(posedge sys_clk)
    begin
        if (rst)
            regRdata_r <= 32'h0;
        else if (regRd)
            regRdata_r <= rdata_nxt;
        else
            regRdata_r <= 32'h0;
    end
endmodule

// file: cwalm_alarm_regs_monitor.sv
`timescale 1ns/100ps
// Watches the alarm register block at its ports
module cwalm_alarm_regs_monitor (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Register port
    input wire [5:0] regAddr,
    input wire [31:0] regWdata,
    input wire regWr,
    input wire regRd,
    input wire [31:0] regRdata_r,
    // Calendar side
    input wire calTick,
    input wire [28:0] dateNext,
    input wire [13:0] yearNext,
    input wire timerIrq,
    input wire [28:0] dateLiveWord_r,
    input wire [13:0] yearLive_r,
    // Interrupts
    input wire alarmIrq_r,
    input wire combinedIrq_r
);
    // One clock domain for every property
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // Load word write cycles
    sequence s_date_load;
        regWr && regAddr == 6'h08;
    endsequence
    sequence s_year_load;
        regWr && regAddr == 6'h14;
    endsequence
    // Live counters, read path and interrupt relations
    date_load_a: assert property (s_date_load |=>
        dateLiveWord_r == $past(regWdata[28:0])) else $error("date load lost");
    year_load_a: assert property (s_year_load |=>
        yearLive_r == $past(regWdata[13:0])) else $error("year load lost");
    date_hold_a: assert property (!calTick && !(regWr && regAddr == 6'h08)
        |=> $stable(dateLiveWord_r)) else $error("live date moved");
    reset_vals_a: assert property ($past(rst) |-> !alarmIrq_r &&
        dateLiveWord_r == 29'h02120000 && yearLive_r == 14'h2000)
        else $error("bad reset values");
    read_idle_a: assert property (!regRd |=> regRdata_r == 32'h0)
        else $error("read data without read");
    year_read_a: assert property (regRd && regAddr == 6'h0C |=>
        regRdata_r == {18'h0, $past(yearLive_r)}) else $error("bad year read");
    irq_or_a: assert property (alarmIrq_r |-> combinedIrq_r)
        else $error("combined irq missing");
    alarm_cause_a: assert property ($rose(alarmIrq_r) |->
        $past(calTick, 2) || $past(regWr) || $past(regWr, 2))
        else $error("alarm without tick");
endmodule

// Attach to the design
bind cwalm_alarm_regs cwalm_alarm_regs_monitor cwalm_alarm_regs_monitor_inst (
    .sys_clk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata_r,
    .calTick, .dateNext, .yearNext, .timerIrq, .dateLiveWord_r, .yearLive_r,
    .alarmIrq_r, .combinedIrq_r);

// file: cwalm_alarm_regs_test.sv
`timescale 1ns/100ps
// Self-checking bench for the alarm register block
module cwalm_alarm_regs_test;
    // Date with time and month at their limits, and a date with zero time and month
    localparam [28:0] FULL = 29'h18F57EFB;
    localparam [28:0] BASE = 29'h00F40000;
    // Stimulus and observed signals
    reg sys_clk = 1'h0, rst = 1'h1, regWr = 1'h0, regRd = 1'h0;
    reg calTick = 1'h0, timerIrq = 1'h0;
    reg [5:0] regAddr = 6'h00;
    reg [31:0] regWdata = 32'h0;
    reg [28:0] dateNext = 29'h0;
    reg [13:0] yearNext = 14'h0;
    wire [31:0] regRdata_r;
    wire [28:0] dateLiveWord_r;
    wire [13:0] yearLive_r;
    wire alarmIrq_r, combinedIrq_r;
    integer miscompares = 0, nTests = 0;
    // Device under test
    cwalm_alarm_regs cwalm_alarm_regs_inst (.sys_clk, .rst, .regAddr,
        .regWdata, .regWr, .regRd, .regRdata_r, .calTick, .dateNext,
        .yearNext, .timerIrq, .dateLiveWord_r, .yearLive_r, .alarmIrq_r,
        .combinedIrq_r);
    // Clock
    initial forever #5 sys_clk = ~sys_clk;
    // Compare and count
    task chk(input [31:0] got, input [31:0] exp);
        nTests = nTests + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Register bus cycles
    task wr(input [5:0] a, input [31:0] d);
        @(posedge sys_clk);
        regWr <= 1'h1;
        regAddr <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWr <= 1'h0;
    endtask
    task rd(input [5:0] a, input [31:0] exp);
        @(posedge sys_clk);
        regRd <= 1'h1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'h0;
        #1 chk(regRdata_r, exp);
    endtask
    // One calendar increment, settled two edges later
    task tick(input [28:0] d, input [13:0] y);
        @(posedge sys_clk);
        calTick <= 1'h1;
        dateNext <= d;
        yearNext <= y;
        @(posedge sys_clk);
        calTick <= 1'h0;
        @(posedge sys_clk);
        #1;
    endtask
    // Program a match, tick, judge the alarm, clear status
    task alm(input [28:0] m, input [28:0] v, input [13:0] y, input e);
        wr(6'h04, {3'h0, m});
        tick(v, y);
        chk(alarmIrq_r, e);
        wr(6'h18, 32'h3);
    endtask
    // Verdict
    task finish_test;
        if (miscompares == 0 && nTests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Reset values, read-only year, unmapped read
    task t_regs;
        rd(6'h00, 32'h02120000);
        rd(6'h04, 32'h0);
        rd(6'h08, 32'h0);
        rd(6'h10, 32'h2000);
        rd(6'h14, 32'h0);
        rd(6'h3C, 32'h0);
        wr(6'h0C, 32'h1234);
        rd(6'h0C, 32'h2000);
    endtask
    // Load words seed the live counters
    task t_load;
        wr(6'h08, {3'h0, FULL});
        rd(6'h00, {3'h0, FULL});
        rd(6'h08, {3'h0, FULL});
        wr(6'h14, 32'h2099);
        rd(6'h0C, 32'h2099);
        rd(6'h14, 32'h2099);
        wr(6'h10, 32'h1999);
        rd(6'h10, 32'h1999);
    endtask
    // Field limits and zero don't-care
    task t_alarm;
        wr(6'h20, 32'h1);
        wr(6'h1C, 32'h1);
        alm(FULL, FULL, 14'h1999, 1'h1);
        alm(BASE | 29'h3C, BASE | 29'h3C, 14'h1999, 1'h0);
        alm(BASE | 29'hF00, BASE | 29'hF00, 14'h1999, 1'h0);
        alm(BASE | 29'h18000, BASE | 29'h18000, 14'h1999, 1'h0);
        alm(BASE | 29'h1A000000, BASE | 29'h1A000000,
            14'h1999, 1'h0);
        alm(29'h0, BASE | 29'h06000000, 14'h1999, 1'h1);
        alm(BASE, BASE | 29'h20000, 14'h1999, 1'h0);
        alm(FULL, FULL, 14'h2000, 1'h0);
    endtask
    // Masking and the combined output
    task t_irq;
        wr(6'h1C, 32'h0);
        wr(6'h04, {3'h0, FULL});
        tick(FULL, 14'h1999);
        chk(alarmIrq_r, 1'h0);
        rd(6'h18, 32'h1);
        wr(6'h1C, 32'h3);
        rd(6'h18, 32'h1);
        chk(alarmIrq_r, 1'h1);
        chk(combinedIrq_r, 1'h1);
        wr(6'h18, 32'h1);
        timerIrq <= 1'h1;
        rd(6'h18, 32'h2);
        timerIrq <= 1'h0;
        chk(alarmIrq_r, 1'h0);
        chk(combinedIrq_r, 1'h1);
    endtask
    // Main sequence
    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'h0;
        t_regs;
        t_load;
        t_alarm;
        t_irq;
        finish_test;
    end
    // Watchdog
    initial
    begin
        #20000;
        miscompares = miscompares + 1;
        finish_test;
    end
endmodule
